/* File: core/alarm_consts.vh */
`ifndef ALARM_CONSTS_VH
`define ALARM_CONSTS_VH
`define ADDR_X_THRESHOLD 7'h20
`define ADDR_Y_THRESHOLD 7'h22
`define ADDR_Z_THRESHOLD 7'h24
`define ADDR_S_THRESHOLD 7'h26
`define ADDR_X_SAMPLES 7'h28
`define ADDR_Y_SAMPLES 7'h2A
`define ADDR_Z_SAMPLES 7'h2C
`define ADDR_ALARM_CONTROL 7'h2E
`define ADDR_DIAG_FLAGS 7'h3C
`define ADDR_GLOBAL_COMMAND 7'h3E
`define CTRL_ENABLE_LSB 0
`define CTRL_SOURCE_LSB 4
`define CTRL_DIR_LSB 8
`define CTRL_DYNAMIC_LSB 12
`define CTRL_USED_MASK 16'h7FFF
`define DIAG_ALARM_LSB 8
`define CMD_CLEAR_BIT 4
`define RST_THRESHOLD 16'h0000
`define RST_CONTROL 16'h0000
`define RST_SAMPLES 8'h01
`endif

/* File: core/alarm_history_ram.v */
`timescale 1ns/100ps
module alarm_history_ram #(
  parameter WIDTH = 16,
  parameter ADDR_BITS = 8
) (
  input wire clk_i,
  input wire we_i,
  input wire [ADDR_BITS-1:0] waddr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire [ADDR_BITS-1:0] raddr_i,
  output reg [WIDTH-1:0] rdata_o
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

/* File: core/threshold_alarm_unit.v */
`timescale 1ns/100ps
`include "alarm_consts.vh"
module threshold_alarm_unit #(
  parameter HIST_BITS = 8
) (
  input wire CLK_I,
  input wire RST_I,
  input wire [6:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WE_I,
  input wire RE_I,
  input wire SAMPLE_VALID_I,
  input wire [15:0] X_ACCEL_I,
  input wire [15:0] Y_ACCEL_I,
  input wire [15:0] Z_ACCEL_I,
  input wire [15:0] X_TILT_I,
  input wire [15:0] Y_TILT_I,
  input wire [15:0] Z_TILT_I,
  input wire [15:0] SUPPLY_I,
  input wire [15:0] TEMP_I,
  output reg [15:0] RDATA_O,
  output reg [3:0] FLAGS_O,
  output reg ALARM_O
);
  reg [15:0] ctrl_q;
  reg [15:0] thr_q [0:3];
  reg [7:0] cnt_q [0:2];
  reg [3:0] flags_q;
  reg [3:0] flags_d;
  reg [HIST_BITS-1:0] wptr_q;
  reg [7:0] fill_q;
  reg eval_q;
  reg [15:0] cur_q [0:2];
  reg [15:0] sys_q;
  reg [3:0] hit;
  reg [16:0] diff;
  reg [16:0] mag;
  reg [15:0] rd_d;
  wire [15:0] rd_old [0:2];
  wire [15:0] src_w [0:2];
  wire clear_cmd;
  integer k;
  integer j;

  function [7:0] eff_count;
    input [7:0] c;
    begin
      // A count of zero is taken as one sample
      eff_count = (c == 8'h00) ? 8'h01 : c;
    end
  endfunction

  function signed_above;
    input [16:0] a;
    input [16:0] b;
    begin
      signed_above = $signed(a) > $signed(b);
    end
  endfunction

  // Sign extension keeps a full-scale difference from wrapping
  function [16:0] sext17;
    input [15:0] v;
    begin
      sext17 = {v[15], v};
    end
  endfunction

  // Equality never trips, in either direction
  function static_hit;
    input dir;
    input [16:0] value;
    input [16:0] lim;
    begin
      if (dir) begin
        static_hit = signed_above(value, lim);
      end else begin
        static_hit = signed_above(lim, value);
      end
    end
  endfunction

  // Falling direction compares against the negated magnitude
  function dynamic_hit;
    input dir;
    input [16:0] delta;
    input [16:0] lim;
    begin
      if (dir) begin
        dynamic_hit = signed_above(delta, lim);
      end else begin
        dynamic_hit = signed_above(17'h00000 - lim, delta);
      end
    end
  endfunction

  // History is unknown after reset until more than count samples have passed
  function sample_ready;
    input [7:0] fill;
    input [7:0] count;
    begin
      sample_ready = fill > eff_count(count);
    end
  endfunction

  function [15:0] axis_source;
    input integer axis;
    input tilt;
    input [47:0] accel;
    input [47:0] incl;
    reg [47:0] pick;
    begin
      pick = tilt ? incl : accel;
      case (axis)
        0: axis_source = pick[15:0];
        1: axis_source = pick[31:16];
        default: axis_source = pick[47:32];
      endcase
    end
  endfunction

  assign clear_cmd = WE_I && (ADDR_I == `ADDR_GLOBAL_COMMAND) &&
                     WDATA_I[`CMD_CLEAR_BIT];

  // Register writes
  always @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_q <= `RST_CONTROL;
      thr_q[0] <= `RST_THRESHOLD;
      thr_q[1] <= `RST_THRESHOLD;
      thr_q[2] <= `RST_THRESHOLD;
      thr_q[3] <= `RST_THRESHOLD;
      cnt_q[0] <= `RST_SAMPLES;
      cnt_q[1] <= `RST_SAMPLES;
      cnt_q[2] <= `RST_SAMPLES;
    end else if (WE_I) begin
      case (ADDR_I)
        `ADDR_ALARM_CONTROL: ctrl_q <= WDATA_I & `CTRL_USED_MASK;
        `ADDR_X_THRESHOLD: thr_q[0] <= WDATA_I;
        `ADDR_Y_THRESHOLD: thr_q[1] <= WDATA_I;
        `ADDR_Z_THRESHOLD: thr_q[2] <= WDATA_I;
        `ADDR_S_THRESHOLD: thr_q[3] <= WDATA_I;
        `ADDR_X_SAMPLES: cnt_q[0] <= WDATA_I[7:0];
        `ADDR_Y_SAMPLES: cnt_q[1] <= WDATA_I[7:0];
        `ADDR_Z_SAMPLES: cnt_q[2] <= WDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Register reads, answered one cycle after the strobe
  always @* begin
    case (ADDR_I)
      `ADDR_ALARM_CONTROL: rd_d = ctrl_q;
      `ADDR_X_THRESHOLD: rd_d = thr_q[0];
      `ADDR_Y_THRESHOLD: rd_d = thr_q[1];
      `ADDR_Z_THRESHOLD: rd_d = thr_q[2];
      `ADDR_S_THRESHOLD: rd_d = thr_q[3];
      `ADDR_X_SAMPLES: rd_d = {8'h00, cnt_q[0]};
      `ADDR_Y_SAMPLES: rd_d = {8'h00, cnt_q[1]};
      `ADDR_Z_SAMPLES: rd_d = {8'h00, cnt_q[2]};
      `ADDR_DIAG_FLAGS: rd_d = {4'h0, flags_q, 8'h00};
      default: rd_d = 16'h0000;
    endcase
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 16'h0000;
    end else if (RE_I) begin
      RDATA_O <= rd_d;
    end
  end

  // History of each axis source, one entry per output sample
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : hist
      wire [HIST_BITS-1:0] raddr;
      assign src_w[g] = axis_source(g, ctrl_q[`CTRL_SOURCE_LSB + g],
        {Z_ACCEL_I, Y_ACCEL_I, X_ACCEL_I}, {Z_TILT_I, Y_TILT_I, X_TILT_I});
      // Entry written count samples ago
      assign raddr = wptr_q - eff_count(cnt_q[g]);
      alarm_history_ram #(
        .WIDTH(16),
        .ADDR_BITS(HIST_BITS)
      ) ram (
        .clk_i(CLK_I),
        .we_i(SAMPLE_VALID_I),
        .waddr_i(wptr_q),
        .wdata_i(src_w[g]),
        .raddr_i(raddr),
        .rdata_o(rd_old[g])
      );
    end
  endgenerate

  // Latest sample per axis; one process so the array has one driver
  always @(posedge CLK_I) begin
    if (RST_I) begin
      for (j = 0; j < 3; j = j + 1) begin
        cur_q[j] <= 16'h0000;
      end
    end else if (SAMPLE_VALID_I) begin
      for (j = 0; j < 3; j = j + 1) begin
        cur_q[j] <= src_w[j];
      end
    end
  end

  // Sample capture; comparison runs the cycle after a fresh sample
  always @(posedge CLK_I) begin
    if (RST_I) begin
      wptr_q <= {HIST_BITS{1'b0}};
      fill_q <= 8'h00;
      eval_q <= 1'b0;
      sys_q <= 16'h0000;
    end else begin
      eval_q <= SAMPLE_VALID_I;
      if (SAMPLE_VALID_I) begin
        wptr_q <= wptr_q + 1'b1;
        if (fill_q != 8'hFF) begin
          fill_q <= fill_q + 8'h01;
        end
        sys_q <= ctrl_q[`CTRL_SOURCE_LSB + 3] ? SUPPLY_I : TEMP_I;
      end
    end
  end

  // Trigger conditions; thresholds share the source's signed format
  always @* begin
    hit = 4'h0;
    diff = 17'h00000;
    mag = 17'h00000;
    for (k = 0; k < 3; k = k + 1) begin
      mag = sext17(thr_q[k]);
      diff = sext17(cur_q[k]) - sext17(rd_old[k]);
      if (ctrl_q[`CTRL_DYNAMIC_LSB + k]) begin
        // Rate limit: change over count samples
        if (sample_ready(fill_q, cnt_q[k])) begin
          hit[k] = dynamic_hit(ctrl_q[`CTRL_DIR_LSB + k], diff, mag);
        end
      end else begin
        hit[k] = static_hit(ctrl_q[`CTRL_DIR_LSB + k], sext17(cur_q[k]),
                            mag);
      end
    end
    mag = sext17(thr_q[3]);
    // System alarm has no dynamic mode
    hit[3] = static_hit(ctrl_q[`CTRL_DIR_LSB + 3], sext17(sys_q),
                        mag);
    hit = hit & ctrl_q[`CTRL_ENABLE_LSB +: 4];
  end

  // Sticky flags; a new trigger beats a clear in the same cycle
  always @* begin
    flags_d = clear_cmd ? 4'h0 : flags_q;
    if (eval_q) begin
      flags_d = flags_d | hit;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Outputs mirror the flags from their own flops, no gate after them
  always @(posedge CLK_I) begin
    if (RST_I) begin
      FLAGS_O <= 4'h0;
      ALARM_O <= 1'b0;
    end else begin
      FLAGS_O <= flags_d;
      ALARM_O <= |flags_d;
    end
  end
endmodule

/* File: sim/alarm_host.sv */
`timescale 1ns/100ps
module alarm_host (
  input wire clk_i,
  input wire [15:0] rdata_i,
  output reg [6:0] addr_o = 7'h00,
  output reg [15:0] wdata_o = 16'h0000,
  output reg we_o = 1'b0,
  output reg re_o = 1'b0
);
  task wr(input [6:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      we_o <= 1'b1;
      @(posedge clk_i);
      we_o <= 1'b0;
    end
  endtask
  // Data is taken one step after the edge so the registered read settles
  task rd(input [6:0] a, output [15:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      re_o <= 1'b1;
      @(posedge clk_i);
      re_o <= 1'b0;
      #1 d = rdata_i;
    end
  endtask
endmodule

/* File: sim/tb_threshold_alarm_unit.sv */
`timescale 1ns/100ps
module tb_threshold_alarm_unit;
  reg clk = 1'b0, rst = 1'b1, sv = 1'b0;
  reg [15:0] din [0:7];
  reg [15:0] thr [0:3];
  reg [15:0] ctl, v;
  reg [3:0] ex;
  reg [31:0] seed = 32'd82559;
  integer failures = 0, total_checks = 0, cycles = 0, i, k;
  wire [6:0] addr;
  wire [15:0] wdata, rdata;
  wire we, re, alarm;
  wire [3:0] flags;
  alarm_host h (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .we_o(we), .re_o(re));
  threshold_alarm_unit dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WE_I(we), .RE_I(re), .SAMPLE_VALID_I(sv),
    .X_ACCEL_I(din[0]), .Y_ACCEL_I(din[1]), .Z_ACCEL_I(din[2]),
    .X_TILT_I(din[3]), .Y_TILT_I(din[4]), .Z_TILT_I(din[5]),
    .SUPPLY_I(din[6]), .TEMP_I(din[7]), .RDATA_O(rdata),
    .FLAGS_O(flags), .ALARM_O(alarm));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function hit(input integer a);
    reg [15:0] x;
    begin
      x = a == 3 ? (ctl[7] ? din[6] : din[7]) : din[ctl[4+a] ? a + 3 : a];
      hit = ctl[a] && (ctl[8+a] ? $signed(x) > $signed(thr[a])
        : $signed(x) < $signed(thr[a]));
    end
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task smp(input r, input [15:0] yv);
    begin
      @(posedge clk);
      for (k = 0; k < 8; k = k + 1) begin
        seed = lfsr(seed);
        din[k] <= r ? seed[15:0] : (k == 1 ? yv : 16'h0000);
      end
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task conclude;
    begin
      if (failures == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      conclude;
    end
  end
  initial begin
    for (k = 0; k < 8; k = k + 1) din[k] = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      h.rd(7'h20 + 2 * i, v);
      chk(v, (i > 3 && i < 7) ? 16'h0001 : 16'h0000);
    end
    h.rd(7'h31, v);
    chk(v, 16'h0000);
    h.wr(7'h2E, 16'hFFFF);
    h.rd(7'h2E, v);
    chk(v, 16'h7FFF);
    // First pass uses zero data and thresholds: equality must not trip
    for (i = 0; i < 40; i = i + 1) begin
      seed = lfsr(seed);
      ctl = {4'h0, seed[11:0]};
      for (k = 0; k < 4; k = k + 1) begin
        seed = lfsr(seed);
        thr[k] = i == 0 ? 16'h0000 : seed[15:0];
        h.wr(7'h20 + 2 * k, thr[k]);
      end
      h.wr(7'h2E, ctl);
      smp(i > 0, 16'h0000);
      for (k = 0; k < 4; k = k + 1) ex[k] = hit(k);
      chk({12'h000, flags}, {12'h000, ex});
      chk({15'h0000, alarm}, {15'h0000, |ex});
      h.rd(7'h3C, v);
      chk(v, {4'h0, ex, 8'h00});
      h.wr(7'h3E, 16'h0010);
      h.rd(7'h3C, v);
      chk(v, 16'h0000);
    end
    h.wr(7'h2E, 16'h0000);
    h.wr(7'h2A, 16'h0003);
    h.wr(7'h22, 16'h0100);
    for (i = 0; i < 3; i = i + 1) smp(1'b0, 16'h0000);
    h.wr(7'h2E, 16'h2202);
    smp(1'b0, 16'h0100);
    chk({12'h000, flags}, 16'h0000);
    smp(1'b0, 16'h0101);
    chk({12'h000, flags}, 16'h0002);
    h.wr(7'h3E, 16'h0010);
    h.wr(7'h2E, 16'h2002);
    for (i = 0; i < 2; i = i + 1) begin
      smp(1'b0, 16'h0000);
      chk({12'h000, flags}, 16'h0000);
    end
    smp(1'b0, 16'h0000);
    chk({12'h000, flags}, 16'h0002);
    conclude;
  end
endmodule

/* File: sim/threshold_alarm_unit_checker.sv */
`timescale 1ns/100ps
module alarm_checker (
  input wire CLK_I,
  input wire RST_I,
  input wire [6:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WE_I,
  input wire RE_I,
  input wire SAMPLE_VALID_I,
  input wire [15:0] RDATA_O,
  input wire [3:0] FLAGS_O,
  input wire ALARM_O
);
  reg [15:0] ctl_q;
  wire clr = WE_I && ADDR_I == 7'h3E && WDATA_I[4];
  always @(posedge CLK_I)
    if (RST_I) ctl_q <= 16'h0000;
    else if (WE_I && ADDR_I == 7'h2E) ctl_q <= WDATA_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  AST_IND: assert property (ALARM_O == |FLAGS_O)
    else $error("indicator differs from flags");
  AST_STICKY: assert property (!$past(clr) |->
    (FLAGS_O & $past(FLAGS_O)) == $past(FLAGS_O)) else $error("flag fell");
  AST_SRC: assert property ((FLAGS_O & ~$past(FLAGS_O)) != 4'h0 |->
    $past(SAMPLE_VALID_I) || $past(SAMPLE_VALID_I, 2) ||
    $past(SAMPLE_VALID_I, 3)) else $error("flag without sample");
  AST_EN: assert property (
    (FLAGS_O & ~$past(FLAGS_O) & ~$past(ctl_q[3:0])) == 4'h0)
    else $error("disabled alarm raised");
  AST_DIAG: assert property (RE_I && ADDR_I == 7'h3C |=>
    RDATA_O == {4'h0, $past(FLAGS_O), 8'h00}) else $error("flag read");
  AST_CTRL: assert property (RE_I && !WE_I && ADDR_I == 7'h2E |=>
    RDATA_O == {1'b0, $past(ctl_q[14:0])}) else $error("control read");
  AST_CLR: assert property (clr && !SAMPLE_VALID_I &&
    !$past(SAMPLE_VALID_I) && !$past(SAMPLE_VALID_I, 2) |=>
    FLAGS_O == 4'h0) else $error("clear missed");
  AST_CNT: assert property (RE_I && ADDR_I == 7'h2A |=>
    RDATA_O[15:8] == 8'h00) else $error("count upper bits set");
  cover property ($rose(ALARM_O));
  cover property ($fell(ALARM_O));
  cover property (FLAGS_O == 4'h2);
endmodule
bind threshold_alarm_unit alarm_checker chk (.CLK_I(CLK_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .RDATA_O(RDATA_O), .FLAGS_O(FLAGS_O),
  .ALARM_O(ALARM_O));
